//--- pkg/cpu_status_pkg.sv
package cpu_status_pkg;

  // ==========================================================
  // Register map (word index, byte address is four times it)
  localparam logic [29:0] STATUS_IDX   = 30'h0000_0003;
  localparam logic [29:0] IRQ_STAT_IDX = 30'h0000_0004;
  localparam logic [29:0] IRQ_MASK_IDX = 30'h0000_0005;

  // ==========================================================
  // Status field positions
  localparam int unsigned IND_BANK_BIT = 7;
  localparam int unsigned PAGE_HI_BIT  = 6;
  localparam int unsigned PAGE_LO_BIT  = 5;
  localparam int unsigned WDT_BIT      = 4;
  localparam int unsigned SLEEP_BIT    = 3;
  localparam int unsigned ZERO_BIT     = 2;
  localparam int unsigned HALF_BIT     = 1;
  localparam int unsigned CARRY_BIT    = 0;
  localparam logic [7:0]  STATUS_RST   = 8'h18;

  // ==========================================================
  // Interrupt event bits
  localparam int unsigned EV_WDT   = 0;
  localparam int unsigned EV_SLEEP = 1;
  localparam int unsigned EV_ZERO  = 2;
  localparam int unsigned EV_W     = 3;

  // ==========================================================
  // Bus constants
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

  // ==========================================================
  // Operations from the execution datapath
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD_REG, OP_ADD_LIT, OP_SUB_LIT, OP_SUB_REG,
    OP_ROT_RIGHT, OP_ROT_LEFT, OP_LOGIC, OP_WRITE, OP_KICK, OP_SLEEP
  } exec_op_e;

  typedef struct packed {
    logic       valid;
    exec_op_e   op;
    logic [7:0] a;
    logic [7:0] b;
    logic       to_status;
  } exec_req_s;

  typedef struct packed {
    logic        hsel;
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ahb_req_s;

  typedef struct packed {
    logic [7:0]      status;
    logic [7:0]      result;
    logic            res_vld;
    logic [8:0]      ind_addr;
    logic [8:0]      dir_addr;
    logic [3:0]      dir_bank;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic            irq;
    logic            wr_status;
    logic            wr_istat;
    logic            wr_imask;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic            hresp;
  } state_s;

endpackage

//--- hdl/cpu_status_flags.sv
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module cpu_status_flags (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire cpu_status_pkg::ahb_req_s   ahb_req,
  input  wire logic [31:0]                hwdata,
  output logic [31:0]                     hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire cpu_status_pkg::exec_req_s  exec_req,
  input  wire logic                       wdt_expire,
  input  wire logic [7:0]                 fsr_addr,
  input  wire logic [6:0]                 dir_offset,
  output logic [7:0]                      result,
  output logic                            result_valid,
  output logic [7:0]                      status,
  output logic [8:0]                      ind_addr,
  output logic [8:0]                      dir_addr,
  output logic [3:0]                      dir_bank,
  output logic                            irq
);

  // ==========================================================
  // Adder with nibble and byte carries: {carry, half, sum}
  function automatic logic [9:0] add8(input logic [7:0] x,
                                      input logic [7:0] y,
                                      input logic       cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    hi = {1'b0, x[7:4]} + {1'b0, y[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  // ==========================================================
  // State
  cpu_status_pkg::state_s st_reg;
  cpu_status_pkg::state_s st_next;
  logic [9:0]                     sum;
  logic [7:0]                     res;
  logic                           new_c;
  logic                           flag_op;
  logic                           take;
  logic [29:0]                    idx;
  logic [cpu_status_pkg::EV_W-1:0] ev;

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    sum = 10'h000;
    res = 8'h00;
    new_c = st_reg.status[cpu_status_pkg::CARRY_BIT];
    flag_op = 1'b0;
    ev = '0;
    st_next.res_vld = 1'b0;
    st_next.hreadyout = 1'b1;
    st_next.hresp = cpu_status_pkg::HRESP_OKAY;

    // Bus data phase writes
    // sleep and expiry kept
    if (st_reg.wr_status) begin
      st_next.status = {hwdata[7:5], st_reg.status[4:3], hwdata[2:0]};
    end
    if (st_reg.wr_imask) begin
      st_next.irq_mask = hwdata[cpu_status_pkg::EV_W-1:0];
    end
    if (st_reg.wr_istat) begin
      st_next.irq_stat = st_reg.irq_stat & ~hwdata[cpu_status_pkg::EV_W-1:0];
    end

    // Datapath operation
    if (exec_req.valid) begin
      // Carry as left by any bus write this cycle
      new_c = st_next.status[cpu_status_pkg::CARRY_BIT];
      case (exec_req.op)
        cpu_status_pkg::OP_ADD_REG, cpu_status_pkg::OP_ADD_LIT: begin
          sum = add8(exec_req.a, exec_req.b, 1'b0);
          flag_op = 1'b1;
        end
        cpu_status_pkg::OP_SUB_LIT, cpu_status_pkg::OP_SUB_REG: begin
          sum = add8(exec_req.a, ~exec_req.b, 1'b1);
          flag_op = 1'b1;
        end
        default: begin
          sum = 10'h000;
        end
      endcase
      case (exec_req.op)
        cpu_status_pkg::OP_ADD_REG, cpu_status_pkg::OP_ADD_LIT,
        cpu_status_pkg::OP_SUB_LIT, cpu_status_pkg::OP_SUB_REG: begin
          res = sum[7:0];
          new_c = sum[9];
          st_next.status[cpu_status_pkg::HALF_BIT] = sum[8];
          st_next.status[cpu_status_pkg::ZERO_BIT] = (sum[7:0] == 8'h00);
        end
        cpu_status_pkg::OP_ROT_RIGHT: begin
          res = {st_reg.status[cpu_status_pkg::CARRY_BIT], exec_req.a[7:1]};
          new_c = exec_req.a[0];
        end
        cpu_status_pkg::OP_ROT_LEFT: begin
          res = {exec_req.a[6:0], st_reg.status[cpu_status_pkg::CARRY_BIT]};
          new_c = exec_req.a[7];
        end
        cpu_status_pkg::OP_LOGIC: begin
          res = exec_req.a;
          st_next.status[cpu_status_pkg::ZERO_BIT] = (exec_req.a == 8'h00);
        end
        cpu_status_pkg::OP_WRITE: begin
          res = exec_req.a;
        end
        cpu_status_pkg::OP_KICK: begin
          st_next.status[cpu_status_pkg::WDT_BIT] = 1'b1;
          st_next.status[cpu_status_pkg::SLEEP_BIT] = 1'b1;
        end
        cpu_status_pkg::OP_SLEEP: begin
          st_next.status[cpu_status_pkg::WDT_BIT] = 1'b1;
          st_next.status[cpu_status_pkg::SLEEP_BIT] = 1'b0;
          ev[cpu_status_pkg::EV_SLEEP] = 1'b1;
        end
        default: begin
          res = 8'h00;
        end
      endcase
      st_next.status[cpu_status_pkg::CARRY_BIT] = new_c;
      st_next.result = res;
      st_next.res_vld = (exec_req.op != cpu_status_pkg::OP_KICK) &&
                        (exec_req.op != cpu_status_pkg::OP_SLEEP) &&
                        (exec_req.op != cpu_status_pkg::OP_NONE);
      ev[cpu_status_pkg::EV_ZERO] = flag_op && (res == 8'h00);
      if (exec_req.to_status && st_next.res_vld) begin
        st_next.status[7:5] = res[7:5];
        if (exec_req.op == cpu_status_pkg::OP_WRITE) begin
          st_next.status[2:0] = res[2:0];
        end
      end
    end

    // Watchdog expiry outranks kick and sleep
    // expiry clears flag
    if (wdt_expire) begin
      st_next.status[cpu_status_pkg::WDT_BIT] = 1'b0;
      ev[cpu_status_pkg::EV_WDT] = 1'b1;
    end

    // Sticky events, set wins over clear
    st_next.irq_stat = st_next.irq_stat | ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

    // Memory address forming
    // indirect top address bit
    st_next.ind_addr = {st_reg.status[cpu_status_pkg::IND_BANK_BIT], fsr_addr};
    st_next.dir_addr = {st_reg.status[6:5], dir_offset};
    st_next.dir_bank = 4'h1 << st_reg.status[6:5];

    // Bus address phase
    take = ahb_req.hsel && ahb_req.hready &&
           (ahb_req.htrans == cpu_status_pkg::HTRANS_NONSEQ);
    idx = ahb_req.haddr[31:2];
    st_next.wr_status = take && ahb_req.hwrite && (idx == cpu_status_pkg::STATUS_IDX);
    st_next.wr_istat = take && ahb_req.hwrite && (idx == cpu_status_pkg::IRQ_STAT_IDX);
    st_next.wr_imask = take && ahb_req.hwrite && (idx == cpu_status_pkg::IRQ_MASK_IDX);
    if (take && !ahb_req.hwrite) begin
      case (idx)
        cpu_status_pkg::STATUS_IDX:   st_next.hrdata = {24'h000000, st_reg.status};
        cpu_status_pkg::IRQ_STAT_IDX: st_next.hrdata = {29'h0, st_reg.irq_stat};
        cpu_status_pkg::IRQ_MASK_IDX: st_next.hrdata = {29'h0, st_reg.irq_mask};
        default:                      st_next.hrdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.status <= cpu_status_pkg::STATUS_RST;
      st_reg.ind_addr <= 9'h000;
      st_reg.dir_bank <= 4'h1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state
  assign hrdata       = st_reg.hrdata;
  assign hreadyout    = st_reg.hreadyout;
  assign hresp        = st_reg.hresp;
  assign result       = st_reg.result;
  assign result_valid = st_reg.res_vld;
  assign status       = st_reg.status;
  assign ind_addr     = st_reg.ind_addr;
  assign dir_addr     = st_reg.dir_addr;
  assign dir_bank     = st_reg.dir_bank;
  assign irq          = st_reg.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic ex_add;
  logic ex_sub;
  assign ex_add = exec_req.valid && (exec_req.op == cpu_status_pkg::OP_ADD_REG ||
                                     exec_req.op == cpu_status_pkg::OP_ADD_LIT);
  assign ex_sub = exec_req.valid && (exec_req.op == cpu_status_pkg::OP_SUB_REG ||
                                     exec_req.op == cpu_status_pkg::OP_SUB_LIT);

  sequence status_wr_addr;
    ahb_req.hsel && ahb_req.hready && ahb_req.hwrite &&
    ahb_req.htrans == cpu_status_pkg::HTRANS_NONSEQ &&
    ahb_req.haddr[31:2] == cpu_status_pkg::STATUS_IDX;
  endsequence

  sequence quiet_data;
    !wdt_expire && !exec_req.valid;
  endsequence

  ind_bank_a: assert property (
    ##1 ind_addr == {$past(status[7]), $past(fsr_addr)})
    else $error("indirect address top bit wrong");

  dir_bank_a: assert property (
    ##1 dir_bank == (4'h1 << $past(status[6:5])) && dir_addr[8:7] == $past(status[6:5]))
    else $error("direct bank decode wrong");

  kick_sets_a: assert property (
    exec_req.valid && exec_req.op == cpu_status_pkg::OP_KICK && !wdt_expire
    |=> status[4] && status[3])
    else $error("kick did not set flags");

  expiry_clr_a: assert property (
    wdt_expire |=> !status[4] && st_reg.irq_stat[cpu_status_pkg::EV_WDT])
    else $error("expiry did not clear flag");

  half_carry_a: assert property (
    ex_add |=> status[1] == (({1'b0, $past(exec_req.a[3:0])} +
                              {1'b0, $past(exec_req.b[3:0])}) > 5'h0f))
    else $error("nibble carry wrong");

  sub_borrow_a: assert property (
    ex_sub |=> status[0] == ($past(exec_req.a) >= $past(exec_req.b)))
    else $error("borrow polarity wrong");

  sub_result_a: assert property (
    ex_sub |=> result == 8'($past(exec_req.a) - $past(exec_req.b)) && result_valid)
    else $error("subtract result wrong");

  rot_carry_a: assert property (
    exec_req.valid && exec_req.op == cpu_status_pkg::OP_ROT_RIGHT
    |=> status[0] == $past(exec_req.a[0]))
    else $error("rotate carry wrong");

  flag_dest_a: assert property (
    ex_add && exec_req.to_status
    |=> status[2] == (result == 8'h00) && status[7:5] == result[7:5])
    else $error("status destination flags wrong");

  sw_ignore_a: assert property (
    status_wr_addr ##1 quiet_data |=> $stable(status[4:3]))
    else $error("software changed hardware flags");

endmodule

//--- testbench/exec_model.sv
`timescale 1ns/1ps
// ==========================================================
// Execution datapath model
module exec_model (
  input  wire logic                 clk,
  output cpu_status_pkg::exec_req_s exec_req,
  output logic                      wdt_expire,
  output logic [7:0]                fsr_addr,
  output logic [6:0]                dir_offset
);
  // Idle values at time zero
  initial begin
    exec_req = '0;
    wdt_expire = 1'b0;
    fsr_addr = 8'h00;
    dir_offset = 7'h00;
  end

  // One-cycle strobe, operands scrambled once it drops
  task automatic issue(input cpu_status_pkg::exec_op_e op, input logic [7:0] a, b,
                       input logic ts);
    @(posedge clk);
    exec_req <= '{1'b1, op, a, b, ts};
    @(posedge clk);
    exec_req <= '{1'b0, cpu_status_pkg::OP_NONE, ~a, ~b, 1'b0};
  endtask

  // One-cycle watchdog expiry pulse
  task automatic expire();
    @(posedge clk);
    wdt_expire <= 1'b1;
    @(posedge clk);
    wdt_expire <= 1'b0;
  endtask

  // New pointer and direct offset
  task automatic addrs(input logic [7:0] f, input logic [6:0] o);
    @(posedge clk);
    fsr_addr <= f;
    dir_offset <= o;
  endtask
endmodule

//--- testbench/cpu_status_flags_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Status flag block bench
module cpu_status_flags_tb;
  logic                       clk;
  logic                       sys_rst;
  logic                       a_sel;
  logic [1:0]                 a_trans;
  logic [31:0]                a_addr;
  logic                       a_wr;
  logic [31:0]                hwdata;
  logic [31:0]                hrdata;
  logic                       hreadyout;
  logic                       hresp;
  cpu_status_pkg::ahb_req_s   ahb_req;
  cpu_status_pkg::exec_req_s  exec_req;
  logic                       wdt_expire;
  logic [7:0]                 fsr_addr;
  logic [6:0]                 dir_offset;
  logic [7:0]                 result;
  logic                       result_valid;
  logic [7:0]                 status;
  logic [8:0]                 ind_addr;
  logic [8:0]                 dir_addr;
  logic [3:0]                 dir_bank;
  logic                       irq;
  int                         n_fail;
  int                         cmp_count;
  logic [7:0]                 st_exp;
  logic [10:0]                e;
  logic [31:0]                rd;
  logic [7:0]                 va [5];
  logic [7:0]                 vb [5];
  cpu_status_pkg::exec_op_e   ops [4];

  localparam logic [31:0] ST_A = {cpu_status_pkg::STATUS_IDX, 2'h0};
  localparam logic [31:0] IS_A = {cpu_status_pkg::IRQ_STAT_IDX, 2'h0};
  localparam logic [31:0] IM_A = {cpu_status_pkg::IRQ_MASK_IDX, 2'h0};

  // Bus hready is the slave's hreadyout, word transfers only
  assign ahb_req = {a_sel, a_trans, a_addr, a_wr, 3'h2, hreadyout};

  cpu_status_flags uut (.clk(clk), .sys_rst(sys_rst), .ahb_req(ahb_req), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .exec_req(exec_req),
    .wdt_expire(wdt_expire), .fsr_addr(fsr_addr), .dir_offset(dir_offset), .result(result),
    .result_valid(result_valid), .status(status), .ind_addr(ind_addr),
    .dir_addr(dir_addr), .dir_bank(dir_bank), .irq(irq));

  exec_model u_exec (.clk(clk), .exec_req(exec_req), .wdt_expire(wdt_expire),
    .fsr_addr(fsr_addr), .dir_offset(dir_offset));

  // Clock generator
  always #5 clk = ~clk;

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Bounded wait for hready
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      results();
    end
  endtask

  // Single AHB transfer, read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] d);
    @(posedge clk);
    a_sel <= 1'b1;
    a_trans <= cpu_status_pkg::HTRANS_NONSEQ;
    a_addr <= addr;
    a_wr <= wr;
    wait_rdy();
    a_sel <= 1'b0;
    a_trans <= 2'h0;
    hwdata <= wr ? d : ~d;
    wait_rdy();
    rd = hrdata;
    check("hresp", hresp, cpu_status_pkg::HRESP_OKAY);
  endtask

  // Expected {zero, half, carry, result}
  function automatic logic [10:0] calc(input cpu_status_pkg::exec_op_e op,
                                       input logic [7:0] a, b, input logic [2:0] f);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    if (op == cpu_status_pkg::OP_SUB_LIT || op == cpu_status_pkg::OP_SUB_REG) begin
      s = {1'b0, a} + {1'b0, ~b} + 9'h001;
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    end
    if (op == cpu_status_pkg::OP_ROT_RIGHT) return {f[2:1], a[0], f[0], a[7:1]};
    if (op == cpu_status_pkg::OP_ROT_LEFT) return {f[2:1], a[7], a[6:0], f[0]};
    return {s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  // Run one op and compare result and whole status byte
  task automatic op_chk(input cpu_status_pkg::exec_op_e op, input logic [7:0] a, b);
    e = calc(op, a, b, st_exp[2:0]);
    st_exp[2:0] = e[10:8];
    u_exec.issue(op, a, b, 1'b0);
    #1;
    check("result", {result_valid, result}, {1'b1, e[7:0]});
    check("status", status, st_exp);
  endtask

  // Watchdog on the whole run
  initial begin
    #200000;
    n_fail++;
    results();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {a_sel, a_trans, a_addr, a_wr, hwdata} = '0;
    n_fail = 0;
    cmp_count = 0;
    va = '{8'h0f, 8'hff, 8'h05, 8'h03, 8'h10};
    vb = '{8'h01, 8'h01, 8'h05, 8'h05, 8'h01};
    ops = '{cpu_status_pkg::OP_ADD_REG, cpu_status_pkg::OP_ADD_LIT,
            cpu_status_pkg::OP_SUB_LIT, cpu_status_pkg::OP_SUB_REG};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    st_exp = cpu_status_pkg::STATUS_RST;
    bus(1'b0, ST_A, 32'h0);
    check("status reset", rd, {24'h0, st_exp});
    bus(1'b1, ST_A, 32'h0);
    bus(1'b0, ST_A, 32'h0);
    check("status write", rd, 32'h18);
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 5; j++) op_chk(ops[i], va[j], vb[j]);
    end
    op_chk(cpu_status_pkg::OP_ROT_RIGHT, 8'h81, 8'h00);
    op_chk(cpu_status_pkg::OP_ROT_LEFT, 8'h7e, 8'h00);
    op_chk(cpu_status_pkg::OP_ROT_LEFT, 8'h80, 8'h00);
    // Flag op aimed at the status register
    u_exec.issue(cpu_status_pkg::OP_ADD_REG, 8'hff, 8'h01, 1'b1);
    #1;
    st_exp = {3'h0, st_exp[4:3], 3'h7};
    check("status dest", status, st_exp);
    // Logic op: zero flag only, result passes through
    u_exec.issue(cpu_status_pkg::OP_LOGIC, 8'h5a, 8'h00, 1'b0);
    #1;
    st_exp[2] = 1'b0;
    check("logic result", {result_valid, result}, {1'b1, 8'h5a});
    check("logic status", status, st_exp);
    // Plain write aimed at the status register, hardware flags kept
    u_exec.issue(cpu_status_pkg::OP_WRITE, 8'ha5, 8'h00, 1'b1);
    #1;
    st_exp = {3'h5, st_exp[4:3], 3'h5};
    check("write result", {result_valid, result}, {1'b1, 8'ha5});
    check("write status", status, st_exp);
    bus(1'b1, IM_A, 32'h0);
    bus(1'b1, IS_A, 32'hf);
    u_exec.expire();
    #1;
    st_exp[4] = 1'b0;
    check("wdt clear", status, st_exp);
    bus(1'b0, IS_A, 32'h0);
    check("irq stat", rd, 32'h1);
    check("irq masked", irq, 1'b0);
    bus(1'b1, IM_A, 32'h1);
    repeat (2) @(posedge clk);
    check("irq on", irq, 1'b1);
    bus(1'b1, IS_A, 32'h1);
    repeat (2) @(posedge clk);
    check("irq off", irq, 1'b0);
    bus(1'b0, 32'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    u_exec.issue(cpu_status_pkg::OP_KICK, 8'h00, 8'h00, 1'b0);
    #1;
    check("kick", status[4:3], 2'h3);
    u_exec.issue(cpu_status_pkg::OP_SLEEP, 8'h00, 8'h00, 1'b0);
    #1;
    check("sleep", status[4:3], 2'h2);
    for (int k = 0; k < 8; k++) begin
      u_exec.addrs(8'h5a ^ 8'(k), 7'h33 ^ 7'(k));
      bus(1'b1, ST_A, {24'h0, 3'(k), 5'h00});
      repeat (3) @(posedge clk);
      #1;
      check("ind addr", ind_addr, {k[2], 8'h5a ^ 8'(k)});
      check("dir addr", dir_addr, {k[1:0], 7'h33 ^ 7'(k)});
      check("dir bank", dir_bank, 4'h1 << k[1:0]);
    end
    results();
  end
endmodule
